// File: dps_defines.vh
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
// ==========================================
// Address and instruction layout
`define DPS_ADDR_FIXED    5'h0b
`define DPS_INS_CHAN      7
`define DPS_INS_MIDRST    6
`define DPS_INS_SOFTOFF   5
`define DPS_INS_OUT2      4
`define DPS_INS_OUT1      3
// ==========================================
// Reset values
`define DPS_WIPER_RESET   8'h80
`define DPS_WIPER_MID     8'h80
`endif

// File: dps_sync.v
// ==========================================
// Two-stage synchroniser for one pin
module dps_sync (
   input  wire clk,
   input  wire rst,
   input  wire din,
   output reg  dout
);
   reg stage1_q;
   // Reset to idle-high bus level so no false start appears
   always @(posedge clk) begin
      if (rst) begin
         stage1_q <= 1'b1;
         dout     <= 1'b1;
      end else begin
         stage1_q <= din;
         dout     <= stage1_q;
      end
   end
endmodule

// File: dps_edge.v
// ==========================================
// Edge finder on an already synchronised line
module dps_edge (
   input  wire clk,
   input  wire rst,
   input  wire lvl,
   output wire rise,
   output wire fall,
   output reg  prev_q
);
   always @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= lvl;
      end
   end
   assign rise = lvl & ~prev_q;
   assign fall = ~lvl & prev_q;
endmodule

// File: dps_serial_ctrl.v
// Overview of operation
// RULE1: Address is 01011 plus two select pins
// RULE2: Acknowledge only when select bits match pins
// RULE3: Controller opens each transfer with start
// RULE4: Matching address acknowledged on ninth clock
// RULE5: Last address bit high reads, low writes
// RULE6: Instruction top bit picks channel
// RULE7: Second bit moves selected wiper to midscale
// RULE8: Third bit shuts down selected channel
// RULE9: Low shutdown pin has same effect
// RULE10: Next two bits drive logic outputs; rest ignored
// RULE11: Third byte loads selected wiper register
// RULE12: Data changes only while clock low
// RULE13: Read sends byte straight after address
// RULE14: Controller ends transfer with stop
// RULE15: Further write bytes reuse same instruction
// RULE16: Further read bytes repeat wiper value
// RULE17: Read returns channel last selected by write
// RULE18: Logic outputs zero after reset
// RULE19: Instruction-only write keeps wiper registers
// RULE20: New command restores wiper after soft shutdown
// RULE21: Each channel holds an 8-bit code
// RULE22: Wipers preset to midscale at reset
// RULE23: Shutdown keeps stored wiper codes
// RULE24: Midscale reset writes 0x80 into register
`include "dps_defines.vh"
module dps_serial_ctrl #(
   parameter DUAL = 1
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       sclIn,
   input  wire       sdaIn,
   output reg        sdaOut,
   output reg        sdaOe,
   input  wire       addrSel0Pin,
   input  wire       addrSel1Pin,
   input  wire       shutdownNPin,
   output reg  [7:0] wiperChannelOne,
   output reg  [7:0] wiperChannelTwo,
   output reg        shutdownOne,
   output reg        shutdownTwo,
   output reg        logicOutOne,
   output reg        logicOutTwo
);
   // ==========================================
   // States
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_INS  = 5'h04;
   localparam [4:0] ST_WDAT = 5'h08;
   localparam [4:0] ST_RDAT = 5'h10;

   wire       sclS;
   wire       sdaS;
   wire       sclRise;
   wire       sclFall;
   wire       sdaRise;
   wire       sdaFall;
   wire       sclPrev;
   wire       sdaPrev;
   wire       startEv;
   wire       stopEv;
   reg  [4:0] state_q;
   reg  [3:0] bitCnt_q;
   reg  [7:0] shift_q;
   reg        ackPhase_q;
   reg        readMode_q;
   reg        chanSel_q;
   reg        softOff1_q;
   reg        softOff2_q;
   reg  [7:0] wiper1_q;
   reg  [7:0] wiper2_q;
   reg  [7:0] txByte_q;
   reg        nack_q;
   reg        pinOff_q;
   wire       offSync;

   // ==========================================
   // Pin synchronisers and edge finders
   dps_sync uSyncScl (.clk(clk), .rst(rst), .din(sclIn), .dout(sclS));
   dps_sync uSyncSda (.clk(clk), .rst(rst), .din(sdaIn), .dout(sdaS));
   dps_sync uSyncShd (.clk(clk), .rst(rst), .din(shutdownNPin), .dout(offSync));
   dps_edge uEdgeScl (.clk(clk), .rst(rst), .lvl(sclS), .rise(sclRise), .fall(sclFall), .prev_q(sclPrev));
   dps_edge uEdgeSda (.clk(clk), .rst(rst), .lvl(sdaS), .rise(sdaRise), .fall(sdaFall), .prev_q(sdaPrev));

   // Start and stop need SCL high both before and now
   assign startEv = sdaFall & sclS & sclPrev; // RULE3
   assign stopEv  = sdaRise & sclS & sclPrev; // RULE14

   // Address match: fixed prefix plus the two synchronised select straps
   function addrMatch;
      input [6:0] a;
      input       p1;
      input       p0;
      begin
         addrMatch = (a[6:2] == `DPS_ADDR_FIXED) && (a[1] == p1) && (a[0] == p0);
      end
   endfunction

   // Straps pass two flops; the compare uses their value when the eighth address bit is sampled
   reg sel0_q, sel1_q, sel0s_q, sel1s_q;
   always @(posedge clk) begin
      if (rst) begin
         sel0_q  <= 1'b0;
         sel1_q  <= 1'b0;
         sel0s_q <= 1'b0;
         sel1s_q <= 1'b0;
      end else begin
         sel0_q  <= addrSel0Pin;
         sel1_q  <= addrSel1Pin;
         sel0s_q <= sel0_q;
         sel1s_q <= sel1_q;
      end
   end

   wire [7:0] rxByte   = {shift_q[6:0], sdaS};
   wire       byteDone = sclRise & ~ackPhase_q & (bitCnt_q == 4'h7);
   wire [7:0] selWiper = chanSel_q ? wiper2_q : wiper1_q; // RULE17

   // ==========================================
   // Protocol engine; bits sampled on SCL rise, driven after SCL fall
   always @(posedge clk) begin
      if (rst) begin
         state_q     <= ST_IDLE;
         bitCnt_q    <= 4'h0;
         shift_q     <= 8'h00;
         ackPhase_q  <= 1'b0;
         readMode_q  <= 1'b0;
         chanSel_q   <= 1'b0;
         softOff1_q  <= 1'b0;
         softOff2_q  <= 1'b0;
         wiper1_q    <= `DPS_WIPER_RESET; // RULE22
         wiper2_q    <= `DPS_WIPER_RESET; // RULE22
         txByte_q    <= 8'h00;
         nack_q      <= 1'b0;
         sdaOut      <= 1'b1;
         sdaOe       <= 1'b0;
         logicOutOne <= 1'b0; // RULE18
         logicOutTwo <= 1'b0; // RULE18
      end else if (startEv) begin
         // Repeated start also lands here, keeping instruction state
         state_q    <= ST_ADDR;
         bitCnt_q   <= 4'h0;
         ackPhase_q <= 1'b0;
         sdaOe      <= 1'b0;
      end else if (stopEv) begin
         state_q <= ST_IDLE;
         sdaOe   <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               sdaOe <= 1'b0;
            end
            ST_ADDR, ST_INS, ST_WDAT: begin
               if (byteDone) begin
                  ackPhase_q <= 1'b1;
                  bitCnt_q   <= 4'h0;
                  if (state_q == ST_ADDR) begin
                     if (addrMatch(rxByte[7:1], sel1s_q, sel0s_q)) begin // RULE1 RULE2
                        readMode_q <= rxByte[0]; // RULE5
                     end else begin
                        state_q <= ST_IDLE; // RULE2
                     end
                  end else if (state_q == ST_INS) begin
                     chanSel_q   <= (DUAL != 0) ? rxByte[`DPS_INS_CHAN] : 1'b0; // RULE6
                     logicOutTwo <= rxByte[`DPS_INS_OUT2]; // RULE10 RULE19
                     logicOutOne <= rxByte[`DPS_INS_OUT1]; // RULE10
                     // Any new command lifts both soft shutdowns first
                     softOff1_q <= 1'b0; // RULE20
                     softOff2_q <= 1'b0; // RULE20
                     if (rxByte[`DPS_INS_CHAN] && DUAL != 0) begin
                        softOff2_q <= rxByte[`DPS_INS_SOFTOFF]; // RULE8
                        if (rxByte[`DPS_INS_MIDRST]) begin
                           wiper2_q <= `DPS_WIPER_MID; // RULE7 RULE24
                        end
                     end else begin
                        softOff1_q <= rxByte[`DPS_INS_SOFTOFF]; // RULE8
                        if (rxByte[`DPS_INS_MIDRST]) begin
                           wiper1_q <= `DPS_WIPER_MID; // RULE7 RULE24
                        end
                     end
                  end else begin
                     // Wiper load; soft shutdown keeps the code underneath
                     if (chanSel_q) begin
                        wiper2_q <= rxByte; // RULE11 RULE15 RULE21 RULE23
                     end else begin
                        wiper1_q <= rxByte; // RULE11 RULE15 RULE21
                     end
                  end
               end else if (sclRise && !ackPhase_q) begin
                  shift_q  <= rxByte;
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (sclFall && ackPhase_q && !sdaOe && bitCnt_q == 4'h0) begin
                  // Drive acknowledge low for the ninth clock
                  sdaOut   <= 1'b0; // RULE4 RULE12
                  sdaOe    <= 1'b1;
                  bitCnt_q <= 4'h1;
               end else if (sclFall && ackPhase_q && sdaOe) begin
                  ackPhase_q <= 1'b0;
                  bitCnt_q   <= 4'h0;
                  if (state_q == ST_ADDR && readMode_q) begin
                     state_q  <= ST_RDAT; // RULE13
                     txByte_q <= {selWiper[6:0], 1'b0};
                     sdaOut   <= selWiper[7]; // RULE12
                     sdaOe    <= ~selWiper[7];
                  end else begin
                     sdaOe <= 1'b0;
                     if (state_q == ST_ADDR) begin
                        state_q <= ST_INS;
                     end else begin
                        state_q <= ST_WDAT; // RULE15
                     end
                  end
               end
            end
            ST_RDAT: begin
               // Open-drain style: drive only zeros, release for ones
               if (sclRise && ackPhase_q) begin
                  nack_q <= sdaS; // RULE13
               end else if (sclRise) begin
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (sclFall && !ackPhase_q && bitCnt_q == 4'h8) begin
                  ackPhase_q <= 1'b1;
                  sdaOe      <= 1'b0;
               end else if (sclFall && !ackPhase_q) begin
                  sdaOut   <= txByte_q[7]; // RULE12
                  sdaOe    <= ~txByte_q[7];
                  txByte_q <= {txByte_q[6:0], 1'b0};
               end else if (sclFall && ackPhase_q) begin
                  ackPhase_q <= 1'b0;
                  bitCnt_q   <= 4'h0;
                  if (nack_q) begin
                     state_q <= ST_IDLE;
                     sdaOe   <= 1'b0;
                  end else begin
                     // Controller acknowledged: repeat the wiper value
                     txByte_q <= {selWiper[6:0], 1'b0}; // RULE16
                     sdaOut   <= selWiper[7];
                     sdaOe    <= ~selWiper[7];
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               sdaOe   <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // Applied outputs; the register code is never lost in shutdown
   always @(posedge clk) begin
      if (rst) begin
         pinOff_q        <= 1'b0;
         shutdownOne     <= 1'b0;
         shutdownTwo     <= 1'b0;
         wiperChannelOne <= `DPS_WIPER_RESET;
         wiperChannelTwo <= `DPS_WIPER_RESET;
      end else begin
         pinOff_q        <= ~offSync; // RULE9
         shutdownOne     <= softOff1_q | pinOff_q; // RULE8 RULE9
         shutdownTwo     <= softOff2_q | pinOff_q; // RULE9
         wiperChannelOne <= wiper1_q; // RULE23
         wiperChannelTwo <= wiper2_q; // RULE23
      end
   end
endmodule

// File: dps_serial_ctrl_asserts.sv
// ==========================================
// Pin-level checks on the serial control block
module dps_serial_ctrl_asserts #(
   parameter DUAL = 1
) (
   input wire       clk,
   input wire       rst,
   input wire       sclIn,
   input wire       sdaIn,
   input wire       sdaOut,
   input wire       sdaOe,
   input wire       addrSel0Pin,
   input wire       addrSel1Pin,
   input wire       shutdownNPin,
   input wire [7:0] wiperChannelOne,
   input wire [7:0] wiperChannelTwo,
   input wire       shutdownOne,
   input wire       shutdownTwo,
   input wire       logicOutOne,
   input wire       logicOutTwo
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Reset presets must show during reset itself, so this one is never disabled
   AST_RST_OUT: assert property (disable iff (1'b0) rst |=> wiperChannelOne == 8'h80 &&
      wiperChannelTwo == 8'h80 && !logicOutOne && !logicOutTwo && !sdaOe) else $error("reset values wrong");
   AST_OPEN_DRAIN: assert property (sdaOe |-> !sdaOut) else $error("data driven high");
   AST_PIN_OFF: assert property (!shutdownNPin [*8] |-> shutdownOne && shutdownTwo)
      else $error("pin shutdown missing");
   AST_ACK_HOLD: assert property ($rose(sdaOe) |-> sdaOe [*5]) else $error("drive too short");
   AST_IDLE_FREE: assert property (sclIn [*8] |-> !sdaOe) else $error("data held in idle");
   // Wipers and outputs move only while the controller owns the data line
   AST_WIPER_ONE: assert property ($changed(wiperChannelOne) |-> !sdaOe && !$past(sdaOe))
      else $error("wiper one moved while driving");
   AST_WIPER_TWO: assert property ($changed(wiperChannelTwo) |-> !sdaOe && !$past(sdaOe))
      else $error("wiper two moved while driving");
   AST_LOGIC_OUT: assert property ($changed({logicOutTwo, logicOutOne}) |-> !sdaOe)
      else $error("logic outputs moved while driving");
   cover property ($rose(sdaOe));
   cover property ($changed(wiperChannelTwo));
   cover property (!shutdownNPin && shutdownOne);
endmodule

bind dps_serial_ctrl dps_serial_ctrl_asserts #(.DUAL(DUAL)) i_asserts (.clk, .rst, .sclIn, .sdaIn, .sdaOut,
   .sdaOe, .addrSel0Pin, .addrSel1Pin, .shutdownNPin, .wiperChannelOne, .wiperChannelTwo, .shutdownOne,
   .shutdownTwo, .logicOutOne, .logicOutTwo);

// File: dps_bus_master.sv
// ==========================================
// Bus controller model, open drain, 200 ns bus clock
module dps_bus_master (
   input  wire  clk,
   input  wire  sdaLine,
   output logic sclOut,
   output logic mstOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus clock stands high and data released outside frames
   initial begin
      sclOut = 1'b1;
      mstOe = 1'b0;
   end
   // Quarter of a bus clock period
   task q();
      repeat (2) @(negedge clk);
   endtask
   // Works from idle and as a repeated start after an acknowledge
   task start();
      mstOe = 1'b0;
      q();
      sclOut = 1'b1;
      q();
      mstOe = 1'b1;
      q();
      sclOut = 1'b0;
      q();
   endtask
   task stop();
      mstOe = 1'b1;
      q();
      sclOut = 1'b1;
      q();
      mstOe = 1'b0;
      q();
      q();
   endtask
   // Data set only while the bus clock is low
   task bitx(input logic b, output logic r);
      mstOe = !b;
      q();
      sclOut = 1'b1;
      q();
      r = sdaLine;
      q();
      sclOut = 1'b0;
      q();
   endtask
   task wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   // Last byte of a read is refused to end it
   task rdByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(last, r);
   endtask
endmodule

// File: dps_serial_ctrl_test.sv
// ==========================================
// Self-checking bench for the serial control block
`define DPS_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end
module dps_serial_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       addrSel0Pin = 1'b0;
   logic       addrSel1Pin = 1'b1;
   logic       shutdownNPin = 1'b1;
   wire        sclIn;
   wire        mstOe;
   wire        sdaOe;
   wire        sdaOut;
   wire [7:0]  wiperChannelOne;
   wire [7:0]  wiperChannelTwo;
   wire        shutdownOne;
   wire        shutdownTwo;
   wire        logicOutOne;
   wire        logicOutTwo;
   wire        sdaIn = !(mstOe || sdaOe);
   int         error_cnt = 0;
   int         samples_checked = 0;
   logic       ack;
   logic [7:0] rd;
   always #12.5 clk = !clk;
   dps_serial_ctrl #(.DUAL(1)) i_dut (.clk, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOe, .addrSel0Pin, .addrSel1Pin,
      .shutdownNPin, .wiperChannelOne, .wiperChannelTwo, .shutdownOne, .shutdownTwo, .logicOutOne, .logicOutTwo);
   dps_bus_master i_mst (.clk, .sdaLine(sdaIn), .sclOut(sclIn), .mstOe);
   task results();
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Start plus address byte, checking whether it is acknowledged
   task addr(input logic [1:0] sel, input logic rw, input logic expAck);
      i_mst.start();
      i_mst.wrByte({5'h0b, sel, rw}, ack);
      `DPS_CHK(ack, expAck)
   endtask
   task wr(input logic [7:0] b);
      i_mst.wrByte(b, ack);
      `DPS_CHK(ack, 1'b1)
   endtask
   // Watchdog, several times the expected run
   initial begin
      #200us;
      error_cnt++;
      results();
   end
   // Main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      `DPS_CHK({wiperChannelTwo, wiperChannelOne}, 16'h8080)
      `DPS_CHK({logicOutTwo, logicOutOne}, 2'b00)
      repeat (8) @(negedge clk);
      addr(2'b01, 1'b0, 1'b0);
      i_mst.stop();
      addr(2'b10, 1'b0, 1'b1);
      wr(8'h18);
      `DPS_CHK({logicOutTwo, logicOutOne}, 2'b11)
      wr(8'h3c);
      `DPS_CHK(wiperChannelOne, 8'h3c)
      wr(8'hc3);
      `DPS_CHK({wiperChannelTwo, wiperChannelOne}, 16'h80c3)
      i_mst.stop();
      addr(2'b10, 1'b0, 1'b1);
      wr(8'h8f);
      `DPS_CHK({logicOutTwo, logicOutOne}, 2'b01)
      wr(8'hff);
      `DPS_CHK(wiperChannelTwo, 8'hff)
      addr(2'b10, 1'b1, 1'b1);
      i_mst.rdByte(1'b0, rd);
      `DPS_CHK(rd, 8'hff)
      i_mst.rdByte(1'b1, rd);
      `DPS_CHK(rd, 8'hff)
      i_mst.stop();
      // Instruction-only write: midscale on channel one, outputs cleared
      addr(2'b10, 1'b0, 1'b1);
      wr(8'h40);
      i_mst.stop();
      `DPS_CHK({wiperChannelTwo, wiperChannelOne}, 16'hff80)
      `DPS_CHK({logicOutTwo, logicOutOne}, 2'b00)
      addr(2'b10, 1'b1, 1'b1);
      i_mst.rdByte(1'b1, rd);
      `DPS_CHK(rd, 8'h80)
      i_mst.stop();
      // Soft shutdown keeps the code, a later command lifts it
      addr(2'b10, 1'b0, 1'b1);
      wr(8'ha0);
      i_mst.stop();
      `DPS_CHK({shutdownTwo, shutdownOne, wiperChannelTwo}, 10'h2ff)
      addr(2'b10, 1'b0, 1'b1);
      wr(8'h80);
      i_mst.stop();
      `DPS_CHK({shutdownTwo, shutdownOne, wiperChannelTwo}, 10'h0ff)
      shutdownNPin = 1'b0;
      repeat (8) @(negedge clk);
      `DPS_CHK({shutdownTwo, shutdownOne}, 2'b11)
      shutdownNPin = 1'b1;
      repeat (8) @(negedge clk);
      `DPS_CHK({shutdownTwo, shutdownOne, wiperChannelTwo}, 10'h0ff)
      results();
   end
endmodule
